// >>> shared/rpu_pkg.sv
// How it works
// - Block muxes patch words into the ROM controller read data path.
// - Eight entries, each a 32-bit match address and 32-bit replacement word pair.
// - Valid bit sets by itself once the word is written after its address; a word written first does not set it.
// - Access address is compared against all eight entries in parallel.
// - Matching enabled entry drives its replacement word instead of ROM data.
// - Among several matching enabled entries the highest number wins.
// - Writing one to a disable strobe bit clears that entry's valid flag.
// - Writing one to an enable strobe bit sets that entry's valid flag.
// - All patch registers are slave registers on the AHB bus.
package rpu_pkg;
	localparam int          ENTRIES       = 8;
	localparam int          IDX_W         = 3;
	localparam logic [11:0] OFS_ENTRY_LO  = 12'h000;
	localparam logic [11:0] OFS_ENTRY_HI  = 12'h03C;
	localparam logic [11:0] OFS_VALID     = 12'h040;
	localparam logic [11:0] OFS_DISABLE   = 12'h044;
	localparam logic [11:0] OFS_ENABLE    = 12'h048;
	localparam logic [7:0]  VALID_RESET   = 8'h00;
	localparam logic [31:0] WORD_RESET    = 32'h0000_0000;
	localparam int          DATA_SEL_BIT  = 2;
	typedef enum logic [1:0] {
		RPU_AH_IDLE  = 2'b00,
		RPU_AH_WRITE = 2'b01,
		RPU_AH_READ  = 2'b10
	} rpu_phase_type;
endpackage

// >>> shared/rpu_match_if.sv
`timescale 1ns/1ps
interface rpu_match_if;
	logic [31:0] addr  [8];
	logic [7:0]  valid;
	logic [31:0] lookup;
	logic        hit;
	logic [2:0]  hit_idx;
	modport regs (output addr, output valid, output lookup, input hit, input hit_idx);
	modport cmp  (input addr, input valid, input lookup, output hit, output hit_idx);
endinterface

// >>> rtl/rpu_match.sv
`timescale 1ns/1ps
module rpu_match (
	rpu_match_if.cmp m
);
	logic [7:0] eq;

	genvar g;
	generate
		for (g = 0; g < rpu_pkg::ENTRIES; g++) begin : g_cmp
			assign eq[g] = m.valid[g] && (m.addr[g] == m.lookup);
		end
	endgenerate

	// Ascending scan so the last hit, the highest entry, wins
	always_comb begin
		m.hit     = 1'b0;
		m.hit_idx = 3'h0;
		for (int i = 0; i < rpu_pkg::ENTRIES; i++) begin
			if (eq[i]) begin
				m.hit     = 1'b1;
				m.hit_idx = 3'(i);
			end
		end
	end
endmodule

// >>> rtl/rpu_top.sv
`timescale 1ns/1ps
module rpu_top (
	input  wire logic        mclk_i,
	input  wire logic        reset_n_i,
	input  wire logic        hsel_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [31:0] hwdata_i,
	input  wire logic        hready_i,
	output logic      [31:0] hrdata_o,
	output logic             hreadyout_o,
	output logic             hresp_o,
	input  wire logic        rom_sel_i,
	input  wire logic [31:0] rom_rdata_i,
	output logic      [31:0] rom_rdata_o
);
	rpu_match_if mif ();

	logic [31:0]                 addr_q     [8];
	logic [31:0]                 next_addr  [8];
	logic [31:0]                 word_q     [8];
	logic [31:0]                 next_word  [8];
	logic [7:0]                  valid_q;
	logic [7:0]                  next_valid;
	logic [7:0]                  addr_seen;
	logic [7:0]                  next_addr_seen;
	rpu_pkg::rpu_phase_type      phase;
	rpu_pkg::rpu_phase_type      next_phase;
	logic [11:0]                 ofs_q;
	logic [11:0]                 next_ofs;
	logic [31:0]                 hrdata;
	logic [31:0]                 next_hrdata;
	logic [31:0]                 rom_q;
	logic [31:0]                 next_rom;
	logic                        rom_pend;
	logic                        next_rom_pend;
	logic                        hit_q;
	logic                        next_hit_q;
	logic [2:0]                  hit_idx_q;
	logic [2:0]                  next_hit_idx_q;
	logic                        ready_q;
	logic                        next_ready;
	logic                        resp_q;
	logic                        next_resp;
	logic [7:0]                  entry_eq;

	rpu_match u_match (.m(mif.cmp));

	always_comb begin
		for (int i = 0; i < 8; i++) begin
			mif.addr[i] = addr_q[i];
		end
		mif.valid  = valid_q;
		mif.lookup = haddr_i;
	end

	wire         take   = hsel_i && hready_i && htrans_i[1];
	wire [2:0]   sel_ix = ofs_q[5:3];

	// Register access: address phase captured, data phase acted on
	always_comb begin
		next_addr      = addr_q;
		next_word      = word_q;
		next_valid     = valid_q;
		next_addr_seen = addr_seen;
		next_ofs       = ofs_q;
		next_hrdata    = hrdata;
		next_phase     = rpu_pkg::RPU_AH_IDLE;
		if (phase == rpu_pkg::RPU_AH_WRITE) begin
			if (ofs_q <= rpu_pkg::OFS_ENTRY_HI) begin
				if (ofs_q[rpu_pkg::DATA_SEL_BIT]) begin
					next_word[sel_ix] = hwdata_i;
					// Word written after its address completes the entry
					if (addr_seen[sel_ix]) begin
						next_valid[sel_ix]     = 1'b1;
						next_addr_seen[sel_ix] = 1'b0;
					end
				end else begin
					next_addr[sel_ix]      = hwdata_i;
					next_addr_seen[sel_ix] = 1'b1;
				end
			end else if (ofs_q == rpu_pkg::OFS_DISABLE) begin
				next_valid = valid_q & ~hwdata_i[7:0];
			end else if (ofs_q == rpu_pkg::OFS_ENABLE) begin
				next_valid = valid_q | hwdata_i[7:0];
			end
		end
		if (take) begin
			next_ofs   = {haddr_i[11:2], 2'b00};
			next_phase = hwrite_i ? rpu_pkg::RPU_AH_WRITE : rpu_pkg::RPU_AH_READ;
			// Read data is fetched now so it leaves a flop in the data phase
			// Next values forward a write still in its data phase to a back-to-back read
			next_hrdata = 32'h0000_0000;
			if ({haddr_i[11:2], 2'b00} <= rpu_pkg::OFS_ENTRY_HI) begin
				next_hrdata = haddr_i[rpu_pkg::DATA_SEL_BIT] ? next_word[haddr_i[5:3]] : next_addr[haddr_i[5:3]];
			end else if ({haddr_i[11:2], 2'b00} == rpu_pkg::OFS_VALID) begin
				next_hrdata = {24'h000000, next_valid};
			end
		end
	end

	// ROM path: the lookup happens in the address phase, the swap in the data phase
	always_comb begin
		next_rom_pend  = rom_sel_i && hready_i && htrans_i[1] && !hwrite_i;
		next_hit_q     = mif.hit;
		next_hit_idx_q = mif.hit_idx;
		next_rom       = rom_q;
		// Zero wait states and an OKAY answer always; held in flops so every output is registered
		next_ready     = 1'b1;
		next_resp      = 1'b0;
		// Extra flop stage costs one cycle of latency but keeps the output registered
		if (rom_pend) begin
			next_rom = hit_q ? word_q[hit_idx_q] : rom_rdata_i;
		end
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			for (int i = 0; i < 8; i++) begin
				addr_q[i] <= rpu_pkg::WORD_RESET;
				word_q[i] <= rpu_pkg::WORD_RESET;
			end
			valid_q     <= rpu_pkg::VALID_RESET;
			addr_seen   <= rpu_pkg::VALID_RESET;
			phase       <= rpu_pkg::RPU_AH_IDLE;
			ofs_q       <= 12'h000;
			hrdata      <= 32'h0000_0000;
			rom_q       <= 32'h0000_0000;
			rom_pend    <= 1'b0;
			hit_q       <= 1'b0;
			hit_idx_q   <= 3'h0;
			ready_q     <= 1'b1;
			resp_q      <= 1'b0;
		end else begin
			addr_q      <= next_addr;
			word_q      <= next_word;
			valid_q     <= next_valid;
			addr_seen   <= next_addr_seen;
			phase       <= next_phase;
			ofs_q       <= next_ofs;
			hrdata      <= next_hrdata;
			rom_q       <= next_rom;
			rom_pend    <= next_rom_pend;
			hit_q       <= next_hit_q;
			hit_idx_q   <= next_hit_idx_q;
			ready_q     <= next_ready;
			resp_q      <= next_resp;
		end
	end

	assign hrdata_o    = hrdata;
	assign rom_rdata_o = rom_q;
	assign hreadyout_o = ready_q;
	assign hresp_o     = resp_q;

	// Independent per-entry match vector, so the priority checks do not lean on the scan itself
	generate
		for (genvar g = 0; g < rpu_pkg::ENTRIES; g++) begin : g_eq
			assign entry_eq[g] = valid_q[g] && (addr_q[g] == haddr_i);
		end
	endgenerate

	valid_sets_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
		(phase == rpu_pkg::RPU_AH_WRITE && ofs_q <= rpu_pkg::OFS_ENTRY_HI && ofs_q[2] && addr_seen[sel_ix])
		|=> valid_q[$past(sel_ix)])
		else $error("entry not validated after address and word");
	disable_clears_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
		(phase == rpu_pkg::RPU_AH_WRITE && ofs_q == rpu_pkg::OFS_DISABLE)
		|=> ((valid_q & $past(hwdata_i[7:0])) == 8'h00))
		else $error("disable strobe left entry valid");
	enable_sets_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
		(phase == rpu_pkg::RPU_AH_WRITE && ofs_q == rpu_pkg::OFS_ENABLE)
		|=> ((valid_q & $past(hwdata_i[7:0])) == $past(hwdata_i[7:0])))
		else $error("enable strobe did not set entry");
	patch_swap_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
		(rom_pend && hit_q) |=> (rom_rdata_o == $past(word_q[hit_idx_q])))
		else $error("patch word not substituted");
	rom_pass_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
		(rom_pend && !hit_q) |=> (rom_rdata_o == $past(rom_rdata_i)))
		else $error("ROM data altered without a match");
	top_priority_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
		(valid_q[7] && addr_q[7] == haddr_i) |-> (mif.hit && mif.hit_idx == 3'h7))
		else $error("entry 7 did not take priority");
	match_hit_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
		(mif.hit) |-> (valid_q[mif.hit_idx] && addr_q[mif.hit_idx] == haddr_i))
		else $error("hit on invalid or unequal entry");
	lookup_delay_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
		(rom_sel_i && hready_i && htrans_i[1] && !hwrite_i) |=> rom_pend)
		else $error("ROM read not tracked");
	valid_hold_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
		(phase != rpu_pkg::RPU_AH_WRITE) |=> (valid_q == $past(valid_q)))
		else $error("valid flags changed without a register write");
	word_alone_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
		(phase == rpu_pkg::RPU_AH_WRITE && ofs_q <= rpu_pkg::OFS_ENTRY_HI && ofs_q[rpu_pkg::DATA_SEL_BIT]
		&& !addr_seen[sel_ix]) |=> (valid_q == $past(valid_q)))
		else $error("word without address validated an entry");
	addr_store_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
		(phase == rpu_pkg::RPU_AH_WRITE && ofs_q <= rpu_pkg::OFS_ENTRY_HI && !ofs_q[rpu_pkg::DATA_SEL_BIT])
		|=> (addr_q[$past(sel_ix)] == $past(hwdata_i)))
		else $error("match address not stored");
	word_store_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
		(phase == rpu_pkg::RPU_AH_WRITE && ofs_q <= rpu_pkg::OFS_ENTRY_HI && ofs_q[rpu_pkg::DATA_SEL_BIT])
		|=> (word_q[$past(sel_ix)] == $past(hwdata_i)))
		else $error("replacement word not stored");
	unmapped_read_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
		(take && !hwrite_i && {haddr_i[11:2], 2'b00} >= rpu_pkg::OFS_DISABLE) |=> (hrdata_o == 32'h0000_0000))
		else $error("write-only or unmapped offset read nonzero");
	miss_none_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
		(entry_eq != 8'h00) |-> mif.hit)
		else $error("enabled matching entry missed");
	highest_hit_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
		(mif.hit) |-> ((entry_eq >> mif.hit_idx) == 8'h01))
		else $error("a higher matching entry was passed over");
	rom_hold_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
		(!rom_pend) |=> (rom_rdata_o == $past(rom_rdata_o)))
		else $error("ROM output changed without a ROM read");
endmodule

// >>> verif/rpu_rom_model.sv
`timescale 1ns/1ps
module rpu_rom_model (
	input  wire logic        mclk_i,
	input  wire logic        rom_sel_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	output logic      [31:0] rom_word_o
);
	logic        act  = 1'b0;
	logic [31:0] a    = 32'h0000_0000;
	logic [31:0] last = 32'h0000_0000;
	always @(posedge mclk_i) begin
		act <= rom_sel_i & htrans_i[1] & ~hwrite_i;
		a   <= haddr_i;
		if (act)
			last <= rom_word_o;
	end
	// Outside a data phase the bus shows inverted data, so a stale word never passes for a fresh one
	always_comb rom_word_o = act ? (a ^ 32'hA5A5_5A5A) : ~last;
endmodule

// >>> verif/rom_patch_unit_tb.sv
`timescale 1ns/1ps
module rom_patch_unit_tb;
	logic        mclk_i    = 1'b0;
	logic        reset_n_i = 1'b0;
	logic        hsel_i    = 1'b0;
	logic        hwrite_i  = 1'b0;
	logic        rom_sel_i = 1'b0;
	logic [1:0]  htrans_i  = 2'h0;
	logic [31:0] haddr_i   = 32'h0000_0000;
	logic [31:0] hwdata_i  = 32'h0000_0000;
	logic [31:0] hrdata_o, rom_rdata_o, rom_word, m;
	logic        hready, hresp;
	logic [31:0] lfsr = 32'h0001_7FDB;
	logic [31:0] ea [8];
	logic [31:0] ed [8];
	logic [7:0]  ev = 8'h00;
	int          fails = 0;
	int          checks = 0;
	always #50 mclk_i = ~mclk_i;
	rpu_top dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
		.htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i), .hready_i(hready),
		.hrdata_o(hrdata_o), .hreadyout_o(hready), .hresp_o(hresp), .rom_sel_i(rom_sel_i),
		.rom_rdata_i(rom_word), .rom_rdata_o(rom_rdata_o));
	rpu_rom_model rom (.mclk_i(mclk_i), .rom_sel_i(rom_sel_i), .haddr_i(haddr_i),
		.htrans_i(htrans_i), .hwrite_i(hwrite_i), .rom_word_o(rom_word));
	function logic [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction
	// Ascending scan, so the highest enabled match is the one left standing
	function logic [31:0] expw(input logic [31:0] a);
		expw = a ^ 32'hA5A5_5A5A;
		for (int i = 0; i < 8; i++)
			if (ev[i] && ea[i] === a)
				expw = ed[i];
	endfunction
	task check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task conclude;
		$display("checks=%0d fails=%0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task wr(input logic [11:0] o, input logic [31:0] v);
		@(posedge mclk_i);
		#1 {hsel_i, hwrite_i, htrans_i, haddr_i} = {4'b1110, 20'h40008, o};
		@(posedge mclk_i);
		#1 {hsel_i, hwrite_i, htrans_i} = 4'h0;
		hwdata_i = v;
	endtask
	task rd(input logic [11:0] o, input logic [31:0] exp);
		@(posedge mclk_i);
		#1 {hsel_i, hwrite_i, htrans_i, haddr_i} = {4'b1010, 20'h40008, o};
		@(posedge mclk_i);
		#1 {hsel_i, htrans_i} = 3'h0;
		check(hrdata_o, exp);
		check({30'h0000_0000, hready, hresp}, 32'h0000_0002);
	endtask
	// Write then read with no idle cycle: the read address phase overlaps the write data phase
	task wr_rd(input logic [11:0] o, input logic [31:0] v, input logic [11:0] ro, input logic [31:0] exp);
		@(posedge mclk_i);
		#1 {hsel_i, hwrite_i, htrans_i, haddr_i} = {4'b1110, 20'h40008, o};
		@(posedge mclk_i);
		#1 {hsel_i, hwrite_i, htrans_i, haddr_i} = {4'b1010, 20'h40008, ro};
		hwdata_i = v;
		@(posedge mclk_i);
		#1 {hsel_i, htrans_i} = 3'h0;
		check(hrdata_o, exp);
	endtask
	task rom_rd(input logic [31:0] a);
		@(posedge mclk_i);
		#1 {rom_sel_i, htrans_i, haddr_i} = {3'b110, a};
		@(posedge mclk_i);
		#1 {rom_sel_i, htrans_i} = 3'h0;
		@(posedge mclk_i);
		#1 check(rom_rdata_o, expw(a));
	endtask
	initial begin
		repeat (10) @(posedge mclk_i);
		#1 reset_n_i = 1'b1;
		rd(12'h040, 32'h0);
		wr(12'h03C, 32'h1234_5678);
		rd(12'h040, 32'h0);
		for (int i = 0; i < 8; i++) begin
			// Entry 5 shadows entry 2 on one word
			ea[i] = (i == 5) ? ea[2] : (rnd() & 32'h0001_FFFC);
			ed[i] = rnd();
			wr(12'(8 * i), ea[i]);
			wr(12'(8 * i + 4), ed[i]);
			ev[i] = 1'b1;
			rd(12'(8 * i), ea[i]);
			rd(12'(8 * i + 4), ed[i]);
			rd(12'h040, {24'h0, ev});
		end
		for (int j = 0; j < 20; j++) begin
			m = (j == 0) ? 32'h0000_0020 : (j == 1) ? 32'h0000_00FF : rnd();
			wr(12'h044, m);
			ev &= ~m[7:0];
			rd(12'h040, {24'h0, ev});
			for (int k = 0; k < 8; k++)
				rom_rd(ea[k]);
			rom_rd(rnd() | 32'h1);
			ev |= m[15:8];
			wr_rd(12'h048, {24'h0, m[15:8]}, 12'h040, {24'h0, ev});
		end
		// Mid-run reset wipes every entry, as a power-up does
		#1 reset_n_i = 1'b0;
		repeat (2) @(posedge mclk_i);
		#1 reset_n_i = 1'b1;
		ev = 8'h00;
		rd(12'h040, 32'h0);
		rom_rd(ea[3]);
		rd(12'h044, 32'h0);
		rd(12'h04C, 32'h0);
		conclude;
	end
	initial begin
		#2_000_000;
		fails++;
		conclude;
	end
endmodule
